// ### logic/pled_driver.sv
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/1ns
`include "pled_defines.svh"

module pled_driver import pled_pkg::*; #(
  parameter int TICK_CYCLES = `PLED_TICK_US * `PLED_CLK_MHZ,
  parameter int PWM_PERIOD_CYCLES = `PLED_PWM_PERIOD_US * `PLED_CLK_MHZ,
  parameter int PWM_ON_CYCLES = `PLED_PWM_ON_US * `PLED_CLK_MHZ
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire pled_phy_status_type PHY_STATUS,
  input wire pled_cfg_type CFG,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR_EN,
  input wire logic RD_EN,
  output logic [31:0] RDATA,
  output logic [3:0] STATUS_INDICATOR_OUTPUTS
);

  // ****************************************
  // timebase constants
  // ****************************************
  localparam logic [23:0] TICK_LAST = 24'(TICK_CYCLES - 1);
  localparam logic [15:0] PWM_LAST = 16'(PWM_PERIOD_CYCLES - 1);
  localparam logic [15:0] PWM_ON = 16'(PWM_ON_CYCLES);
  localparam int STRETCH_BASE_TICKS = (`PLED_STRETCH_BASE_MS * 1000) / `PLED_TICK_US;

  pled_state_type r;
  pled_state_type n;
  logic tick;
  logic pwm_on;
  logic act;
  logic [3:0] prim;
  logic [3:0] evt;
  logic [3:0] drive;

  // ****************************************
  // decoding helpers
  // ****************************************
  function automatic logic link_match(input logic [3:0] fn, input pled_phy_status_type s);
    logic g;
    logic f;
    logic t;
    g = s.link && (s.speed == SPD_1000);
    f = s.link && (s.speed == SPD_100);
    t = s.link && (s.speed == SPD_10);
    case (fn)
      `PLED_FN_LINK_ANY: link_match = s.link;
      `PLED_FN_LINK_G: link_match = g;
      `PLED_FN_LINK_F: link_match = f;
      `PLED_FN_LINK_T: link_match = t;
      `PLED_FN_LINK_FG: link_match = f | g;
      `PLED_FN_LINK_TG: link_match = t | g;
      `PLED_FN_LINK_TF: link_match = t | f;
      default: link_match = 1'b0;
    endcase
  endfunction

  function automatic logic primary_of(input logic [3:0] fn, input pled_phy_status_type s);
    case (fn)
      `PLED_FN_DUPLEX: primary_of = s.link && s.full_duplex;
      `PLED_FN_FAULT: primary_of = s.aneg_fault;
      `PLED_FN_ON: primary_of = 1'b1;
      `PLED_FN_OFF: primary_of = 1'b0;
      default: primary_of = link_match(fn, s);
    endcase
  endfunction

  function automatic logic secondary_of(input logic [3:0] fn, input pled_phy_status_type s, input logic a);
    case (fn)
      `PLED_FN_DUPLEX: secondary_of = s.link && !s.full_duplex && s.collision;
      `PLED_FN_COLL: secondary_of = s.collision;
      `PLED_FN_ACT: secondary_of = a;
      default: secondary_of = link_match(fn, s) && a;
    endcase
  endfunction

  // codes without a secondary condition ignore a stretch left over from an earlier code
  function automatic logic fixed_level(input logic [3:0] fn);
    case (fn)
      `PLED_FN_OFF, `PLED_FN_ON, `PLED_FN_FAULT: fixed_level = 1'b1;
      4'h7, 4'hb, 4'hd: fixed_level = 1'b1;
      default: fixed_level = 1'b0;
    endcase
  endfunction

  // half period of blink is 2^(3-rate) ticks: 200, 100, 50, 25 ms
  function automatic logic blink_phase(input logic [3:0] tc, input logic [1:0] rate);
    blink_phase = tc[2'd3 - rate];
  endfunction

  // stretch length 50, 100, 200, 400 ms in ticks
  function automatic logic [4:0] stretch_len(input logic [1:0] rate);
    stretch_len = 5'(STRETCH_BASE_TICKS) << rate;
  endfunction

  function automatic pled_state_type apply_behav(input pled_state_type s, input logic [31:0] w);
    pled_state_type o;
    o = s;
    o.pol = w[`PLED_BV_POL_LSB +: 4];
    o.comb_dis = w[`PLED_BV_COMB_LSB +: 4];
    o.str_en = w[`PLED_BV_STR_LSB +: 4];
    o.rate = w[`PLED_BV_RATE_LSB +: 8];
    o.pulse_en = w[`PLED_BV_PULSE_BIT];
    o.tx_only = w[`PLED_BV_TXONLY_BIT];
    apply_behav = o;
  endfunction

  function automatic logic [31:0] behav_word(input pled_state_type s);
    logic [31:0] w;
    w = '0;
    w[`PLED_BV_POL_LSB +: 4] = s.pol;
    w[`PLED_BV_COMB_LSB +: 4] = s.comb_dis;
    w[`PLED_BV_STR_LSB +: 4] = s.str_en;
    w[`PLED_BV_RATE_LSB +: 8] = s.rate;
    w[`PLED_BV_PULSE_BIT] = s.pulse_en;
    w[`PLED_BV_TXONLY_BIT] = s.tx_only;
    behav_word = w;
  endfunction

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    n = r;
    tick = (r.pre == TICK_LAST);
    n.pre = tick ? 24'h0 : r.pre + 24'h1;
    if (tick) begin
      n.tick_cnt = r.tick_cnt + 4'h1;
    end
    n.pwm = (r.pwm == PWM_LAST) ? 16'h0 : r.pwm + 16'h1;
    pwm_on = (r.pwm < PWM_ON);
    act = r.tx_only ? PHY_STATUS.tx_act : (PHY_STATUS.tx_act | PHY_STATUS.rx_act);
    for (int i = 0; i < 4; i++) begin
      prim[i] = primary_of(r.func[i], PHY_STATUS);
      evt[i] = secondary_of(r.func[i], PHY_STATUS, act) && !r.comb_dis[i];
      case (r.st[i])
        ST_IDLE: begin
          if (r.str_en[i] && evt[i]) begin
            n.st[i] = ST_ON;
            n.scnt[i] = stretch_len(r.rate[i]);
          end
        end
        ST_ON: begin
          if (!r.str_en[i]) begin
            n.st[i] = ST_IDLE;
          end else if (tick && r.scnt[i] == 5'h0) begin
            n.st[i] = ST_OFF;
            n.scnt[i] = stretch_len(r.rate[i]);
          end else if (tick) begin
            n.scnt[i] = r.scnt[i] - 5'h1;
          end
        end
        ST_OFF: begin
          if (!r.str_en[i] || (tick && r.scnt[i] == 5'h0)) begin
            n.st[i] = ST_IDLE;
          end else if (tick) begin
            n.scnt[i] = r.scnt[i] - 5'h1;
          end
        end
        default: n.st[i] = ST_IDLE;
      endcase
      // stretch shows the opposite of the primary state while on
      if (r.str_en[i] && !fixed_level(r.func[i])) begin
        n.lvl[i] = (r.st[i] == ST_ON) ? !prim[i] : prim[i];
      end else begin
        n.lvl[i] = evt[i] ? blink_phase(r.tick_cnt, r.rate[i]) : prim[i];
      end
      drive[i] = n.lvl[i] && (!r.pulse_en || pwm_on);
      n.pin[i] = r.pol[i] ? drive[i] : !drive[i];
    end
    // nonvolatile load first, so a same-cycle register write wins
    if (CFG.load) begin
      n.func = CFG.func;
      n = apply_behav(n, CFG.behav);
    end
    if (WR_EN) begin
      case (ADDR)
        `PLED_ADDR_FUNC: n.func = WDATA[15:0];
        `PLED_ADDR_BEHAV: n = apply_behav(n, WDATA);
        default: ;
      endcase
    end
    n.rdata = 32'h0;
    if (RD_EN) begin
      case (ADDR)
        `PLED_ADDR_FUNC: n.rdata = {16'h0, r.func};
        `PLED_ADDR_BEHAV: n.rdata = behav_word(r);
        `PLED_ADDR_STATUS: begin
          for (int k = 0; k < 4; k++) begin
            n.rdata[4 + k] = (r.st[k] != ST_IDLE);
          end
          n.rdata[3:0] = r.lvl;
        end
        default: n.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      r <= '0;
      r.func <= `PLED_FUNC_RST;
      r.pin <= `PLED_PIN_RST;
    end else begin
      r <= n;
    end
  end

  assign RDATA = r.rdata;
  assign STATUS_INDICATOR_OUTPUTS = r.pin;

  // ****************************************
  // indicator checks on indicator 0, chk_other_outputs on indicator 1, and register, read data and prescaler checks on the whole block
  // ****************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  logic quiet0;
  assign quiet0 = !r.pulse_en && !r.pol[0];

  chk_forced_on_low: assert property (
    (r.func[0] == `PLED_FN_ON) && quiet0 |=> STATUS_INDICATOR_OUTPUTS[0] == 1'b0)
    else $error("forced on indicator not driven low");

  chk_forced_off_high: assert property (
    (r.func[0] == `PLED_FN_OFF) |=> STATUS_INDICATOR_OUTPUTS[0] == $past(!r.pol[0]))
    else $error("forced off indicator not deasserted");

  chk_reserved_code_off: assert property (
    (r.func[0] == 4'h7 || r.func[0] == 4'hb || r.func[0] == 4'hd)
    |=> STATUS_INDICATOR_OUTPUTS[0] == $past(!r.pol[0]))
    else $error("reserved function drove the indicator");

  chk_polarity_invert: assert property (
    (r.func[0] == `PLED_FN_ON) && !r.pulse_en && r.pol[0] |=> STATUS_INDICATOR_OUTPUTS[0] == 1'b1)
    else $error("inverted polarity not applied");

  chk_no_link_off: assert property (
    (r.func[0] == `PLED_FN_LINK_ANY) && !PHY_STATUS.link && !r.str_en[0] |=> STATUS_INDICATOR_OUTPUTS[0] == 1'b1 || $past(r.pol[0]))
    else $error("indicator asserted without link");

  chk_speed_mismatch: assert property (
    (r.func[0] == `PLED_FN_LINK_G) && PHY_STATUS.speed != SPD_1000 && !r.str_en[0] && !r.pol[0]
    |=> STATUS_INDICATOR_OUTPUTS[0] == 1'b1)
    else $error("gigabit indicator asserted at other speed");

  chk_fault_on: assert property (
    (r.func[0] == `PLED_FN_FAULT) && PHY_STATUS.aneg_fault && !r.str_en[0] && quiet0
    |=> STATUS_INDICATOR_OUTPUTS[0] == 1'b0)
    else $error("fault indicator not asserted");

  chk_collision_quiet: assert property (
    (r.func[0] == `PLED_FN_COLL) && !PHY_STATUS.collision && r.st[0] == ST_IDLE && !r.pol[0]
    |=> STATUS_INDICATOR_OUTPUTS[0] == 1'b1)
    else $error("collision indicator active without collision");

  chk_combine_primary: assert property (
    (r.func[0] == `PLED_FN_LINK_ANY) && PHY_STATUS.link && r.comb_dis[0] && !r.str_en[0] && quiet0
    |=> STATUS_INDICATOR_OUTPUTS[0] == 1'b0)
    else $error("combine disable did not hide activity");

  chk_blink_phase: assert property (
    (r.func[0] == `PLED_FN_ACT) && act && !r.comb_dis[0] && !r.str_en[0] && quiet0
    |=> STATUS_INDICATOR_OUTPUTS[0] == !$past(blink_phase(r.tick_cnt, r.rate[0])))
    else $error("blink does not follow the rate phase");

  chk_pulse_gap: assert property (
    r.pulse_en && !r.pol[0] && r.pwm >= PWM_ON |=> STATUS_INDICATOR_OUTPUTS[0] == 1'b1)
    else $error("pulsed indicator asserted outside its duty window");

  sequence s_stretch_start;
    r.st[0] == ST_IDLE && r.str_en[0] && evt[0] ##1 r.st[0] == ST_ON;
  endsequence

  chk_stretch_load: assert property (
    s_stretch_start |-> r.scnt[0] == stretch_len($past(r.rate[0])))
    else $error("stretch period not loaded from rate");

  chk_stretch_hold: assert property (
    s_stretch_start |-> r.st[0] == ST_ON [*2])
    else $error("stretch on phase ended too soon");

  chk_cfg_load: assert property (
    CFG.load && !WR_EN |=> r.func == $past(CFG.func))
    else $error("nonvolatile settings not loaded");

  chk_write_func: assert property (
    WR_EN && ADDR == `PLED_ADDR_FUNC |=> r.func == $past(WDATA[15:0]))
    else $error("function register write lost");

  chk_read_once: assert property (
    !RD_EN |=> RDATA == 32'h0)
    else $error("read data outlived its cycle");

  chk_duplex_full: assert property (
    (r.func[0] == `PLED_FN_DUPLEX) && PHY_STATUS.link && PHY_STATUS.full_duplex && !r.str_en[0] && quiet0
    |=> STATUS_INDICATOR_OUTPUTS[0] == 1'b0)
    else $error("full duplex link not shown");

  chk_duplex_half: assert property (
    (r.func[0] == `PLED_FN_DUPLEX) && !PHY_STATUS.full_duplex && !PHY_STATUS.collision
    && r.st[0] == ST_IDLE && !r.pol[0] |=> STATUS_INDICATOR_OUTPUTS[0] == 1'b1)
    else $error("half duplex link shown as full");

  chk_pair_match: assert property (
    (r.func[0] == `PLED_FN_LINK_FG) && PHY_STATUS.link && PHY_STATUS.speed != SPD_10 && !act
    && !r.str_en[0] && quiet0 |=> STATUS_INDICATOR_OUTPUTS[0] == 1'b0)
    else $error("two-speed link not shown");

  chk_pair_miss: assert property (
    (r.func[0] == `PLED_FN_LINK_TF) && PHY_STATUS.speed == SPD_1000 && !r.str_en[0] && !r.pol[0]
    |=> STATUS_INDICATOR_OUTPUTS[0] == 1'b1)
    else $error("two-speed indicator asserted at other speed");

  chk_tx_only_mask: assert property (
    (r.func[0] == `PLED_FN_ACT) && r.tx_only && !PHY_STATUS.tx_act && r.st[0] == ST_IDLE && !r.pol[0]
    |=> STATUS_INDICATOR_OUTPUTS[0] == 1'b1)
    else $error("receive activity shown in transmit only mode");

  chk_rx_counts: assert property (
    (r.func[0] == `PLED_FN_ACT) && !r.tx_only && PHY_STATUS.rx_act && !r.comb_dis[0] && !r.str_en[0] && quiet0
    |=> STATUS_INDICATOR_OUTPUTS[0] == !$past(blink_phase(r.tick_cnt, r.rate[0])))
    else $error("receive activity not shown");

  chk_rate_fast: assert property (
    (r.func[0] == `PLED_FN_ACT) && act && !r.comb_dis[0] && !r.str_en[0] && quiet0 && r.rate[0] == 2'h3
    |=> STATUS_INDICATOR_OUTPUTS[0] == !$past(r.tick_cnt[0]))
    else $error("fastest blink rate not applied");

  chk_tick_wrap: assert property (
    r.pre == TICK_LAST |=> r.pre == 24'h0 && r.tick_cnt == $past(r.tick_cnt) + 4'h1)
    else $error("tick prescaler did not wrap");

  chk_pwm_wrap: assert property (
    r.pwm == PWM_LAST |=> r.pwm == 16'h0)
    else $error("pulsing prescaler did not wrap");

  chk_other_outputs: assert property (
    (r.func[1] == `PLED_FN_ON) && !r.pulse_en && !r.pol[1] |=> STATUS_INDICATOR_OUTPUTS[1] == 1'b0)
    else $error("second indicator ignores its own selector");

  chk_stretch_abort: assert property (
    r.st[0] != ST_IDLE && !r.str_en[0] |=> r.st[0] == ST_IDLE)
    else $error("stretch kept running after disable");

endmodule // pled_driver

// ### logic/pled_defines.svh
`ifndef PLED_DEFINES_SVH
`define PLED_DEFINES_SVH

// ****************************************
// register map
// ****************************************
`define PLED_ADDR_FUNC 8'h00
`define PLED_ADDR_BEHAV 8'h04
`define PLED_ADDR_STATUS 8'h08

// behaviour word field positions
`define PLED_BV_POL_LSB 0
`define PLED_BV_COMB_LSB 4
`define PLED_BV_STR_LSB 8
`define PLED_BV_RATE_LSB 12
`define PLED_BV_PULSE_BIT 20
`define PLED_BV_TXONLY_BIT 21

// reset values
`define PLED_FUNC_RST 16'h3210
`define PLED_BEHAV_RST 32'h0000_0000
`define PLED_PIN_RST 4'hf

// ****************************************
// function codes
// ****************************************
`define PLED_FN_LINK_ANY 4'h0
`define PLED_FN_LINK_G 4'h1
`define PLED_FN_LINK_F 4'h2
`define PLED_FN_LINK_T 4'h3
`define PLED_FN_LINK_FG 4'h4
`define PLED_FN_LINK_TG 4'h5
`define PLED_FN_LINK_TF 4'h6
`define PLED_FN_DUPLEX 4'h8
`define PLED_FN_COLL 4'h9
`define PLED_FN_ACT 4'ha
`define PLED_FN_FAULT 4'hc
`define PLED_FN_OFF 4'he
`define PLED_FN_ON 4'hf

// ****************************************
// timing
// ****************************************
`define PLED_CLK_MHZ 50
`define PLED_TICK_US 25000
`define PLED_STRETCH_BASE_MS 50
`define PLED_PWM_PERIOD_US 200
`define PLED_PWM_ON_US 40

`endif

// ### logic/pled_pkg.sv
package pled_pkg;

  typedef enum logic [1:0] {SPD_10, SPD_100, SPD_1000} pled_speed_type;

  typedef enum logic [1:0] {ST_IDLE, ST_ON, ST_OFF} pled_stretch_type;

  typedef struct packed {
    logic link;
    pled_speed_type speed;
    logic full_duplex;
    logic tx_act;
    logic rx_act;
    logic collision;
    logic aneg_fault;
  } pled_phy_status_type;

  typedef struct packed {
    logic load;
    logic [15:0] func;
    logic [31:0] behav;
  } pled_cfg_type;

  typedef struct packed {
    logic [3:0][3:0] func;
    logic [3:0] pol;
    logic [3:0] comb_dis;
    logic [3:0] str_en;
    logic [3:0][1:0] rate;
    logic pulse_en;
    logic tx_only;
    logic [23:0] pre;
    logic [3:0] tick_cnt;
    logic [15:0] pwm;
    pled_stretch_type [3:0] st;
    logic [3:0][4:0] scnt;
    logic [3:0] lvl;
    logic [3:0] pin;
    logic [31:0] rdata;
  } pled_state_type;

endpackage

// ### sim/pled_led_board.sv
`timescale 1ns/1ns

// ****************************************
// indicator leds on the board
// ****************************************
module pled_led_board (
  input wire logic CLK,
  input wire logic [3:0] PIN,
  input wire logic CLR,
  output logic [3:0] LIT,
  output logic [3:0][15:0] LIT_CNT
);
  // leds hang from the supply rail, so a low pin lights them
  assign LIT = ~PIN;

  // lit cycles per led since the last clear
  always_ff @(posedge CLK) begin
    for (int i = 0; i < 4; i++) begin
      LIT_CNT[i] <= CLR ? 16'h0 : LIT_CNT[i] + {15'h0, LIT[i]};
    end
  end
endmodule // pled_led_board

// ### sim/pled_driver_tb.sv
`timescale 1ns/1ns
`include "pled_defines.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end

module pled_driver_tb import pled_pkg::*;;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic clr = 1'b0;
  logic rd_d = 1'b0;
  logic [1:0] chk = 2'd0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [3:0] pins;
  logic [3:0] lit;
  logic [3:0][15:0] cnt;
  logic [63:0] want;
  logic [63:0] got;
  logic [63:0] expq[$];
  logic [31:0] rdq[$];
  pled_phy_status_type phy = '0;
  pled_cfg_type cfg = '0;
  int n_errors = 0;
  int compares = 0;

  pled_driver #(.TICK_CYCLES(8), .PWM_PERIOD_CYCLES(10), .PWM_ON_CYCLES(2)) i_pled_driver (
    .CLK(clk), .RESETN(resetn), .PHY_STATUS(phy), .CFG(cfg), .ADDR(addr), .WDATA(wdata),
    .WR_EN(wr_en), .RD_EN(rd_en), .RDATA(rdata), .STATUS_INDICATOR_OUTPUTS(pins));

  pled_led_board i_pled_led_board (.CLK(clk), .PIN(pins), .CLR(clr), .LIT(lit), .LIT_CNT(cnt));

  initial begin
    forever #10 clk = ~clk;
  end

  // ****************************************
  // bus tasks and expectations
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ld = 1'b0);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    cfg.load <= ld;
    @(posedge clk);
    wr_en <= 1'b0;
    cfg.load <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    rdq.push_back(e);
    @(posedge clk);
    rd_en <= 1'b0;
  endtask

  // kind 1 pins, 2 lit counts, 3 stretch length on led 0
  task automatic see(input logic [1:0] k, input logic [63:0] e, input int n = 4, input logic hit = 1'b0);
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    phy.collision <= hit;
    @(posedge clk);
    phy.collision <= 1'b0;
    repeat (n - 1) @(posedge clk);
    expq.push_back(e);
    chk <= k;
    @(posedge clk);
    chk <= 2'd0;
  endtask

  function automatic logic prim(input logic [3:0] f, input pled_phy_status_type s);
    logic g;
    logic m;
    logic t;
    g = s.speed == SPD_1000;
    m = s.speed == SPD_100;
    t = s.speed == SPD_10;
    case (f)
      4'h0: return s.link;
      4'h1: return s.link & g;
      4'h2: return s.link & m;
      4'h3: return s.link & t;
      4'h4: return s.link & (m | g);
      4'h5: return s.link & (t | g);
      4'h6: return s.link & (t | m);
      4'h8: return s.link & s.full_duplex;
      4'hc: return s.aneg_fault;
      4'hf: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  task automatic final_report;
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ****************************************
  // result monitor
  // ****************************************
  always @(posedge clk) begin
    if (rd_d) begin
      want = {32'h0, rdq.pop_front()};
      `CHK({32'h0, rdata}, want)
    end
    if (chk != 2'd0) begin
      want = expq.pop_front();
      got = chk == 2'd1 ? {60'h0, pins} : chk == 2'd2 ? cnt : {63'h0, cnt[0] >= 16'd16 && cnt[0] <= 16'd25};
      `CHK(got, want)
    end
    rd_d <= rd_en;
  end

  initial begin
    #400000;
    n_errors++;
    final_report;
  end

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    void'($urandom(39844));
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    see(2'd1, 64'hf);
    rd(`PLED_ADDR_FUNC, {16'h0, `PLED_FUNC_RST});
    rd(`PLED_ADDR_BEHAV, `PLED_BEHAV_RST);
    rd(8'h0c, 32'h0);
    for (int i = 0; i < 32; i++) begin
      phy.link <= 1'($urandom);
      phy.speed <= pled_speed_type'($urandom_range(2));
      phy.full_duplex <= 1'($urandom);
      phy.aneg_fault <= 1'($urandom);
      wr(`PLED_ADDR_FUNC, {16'h0, {4{i[3:0]}}});
      see(2'd1, {60'h0, {4{~prim(i[3:0], phy)}}});
    end
    wr(`PLED_ADDR_FUNC, 32'h0000_fefe);
    see(2'd1, 64'h5);
    wr(`PLED_ADDR_BEHAV, 32'h0000_0003);
    see(2'd1, 64'h6);
    cfg.func <= 16'hffff;
    cfg.behav <= 32'h0;
    wr(8'h0c, 32'hffff_ffff, 1'b1);
    see(2'd1, 64'h0);
    rd(`PLED_ADDR_FUNC, 32'h0000_ffff);
    cfg.func <= 16'h0000;
    wr(`PLED_ADDR_FUNC, 32'h0000_eeee, 1'b1);
    see(2'd1, 64'hf);
    phy.tx_act <= 1'b1;
    wr(`PLED_ADDR_BEHAV, 32'h000e_4000);
    wr(`PLED_ADDR_FUNC, 32'h0000_aaaa);
    see(2'd2, {4{16'd256}}, 512);
    phy.tx_act <= 1'b0;
    phy.rx_act <= 1'b1;
    wr(`PLED_ADDR_BEHAV, 32'h002e_4000);
    see(2'd2, 64'h0, 64);
    wr(`PLED_ADDR_BEHAV, 32'h000e_4000);
    see(2'd2, {4{16'd256}}, 512);
    phy.link <= 1'b1;
    wr(`PLED_ADDR_FUNC, 32'h0000_0000);
    wr(`PLED_ADDR_BEHAV, 32'h0000_00f0);
    see(2'd2, {4{16'd64}}, 64);
    rd(`PLED_ADDR_STATUS, 32'h0000_000f);
    wr(`PLED_ADDR_FUNC, 32'h0000_efff);
    wr(`PLED_ADDR_BEHAV, 32'h0010_0000);
    see(2'd2, {16'd0, {3{16'd20}}}, 100);
    phy.rx_act <= 1'b0;
    phy.link <= 1'b0;
    wr(`PLED_ADDR_FUNC, 32'h0000_9999);
    wr(`PLED_ADDR_BEHAV, 32'h0000_0f00);
    see(2'd3, 64'h1, 48, 1'b1);
    repeat (4) @(posedge clk);
    final_report;
  end
endmodule // pled_driver_tb
